// ---- mel_pkg.sv ----
// Constants, types and check-bit helpers for the memory error log block.
// Assumes one 25 MHz clock and a 22-bit storage word of 16 data and 6 check bits.
// Operation
// - Classify each syndrome as correctable single-bit or uncorrectable multiple-bit.
// - A detected error is registered, prioritised and reported as a log change.
// - Single-bit errors are corrected in the data path, logged, operation continues.
// - Uncorrectable errors record requester type and pulse the uncorrectable signal.
// - A 16-bit write crossing a stack disables error checking; only the limit check can still report.
// - Writes shorter than 16 bits store inverted check bits.
// - Addresses beyond the installed limit raise the out-of-range signal.
// - A second error of a logged type sets the duplicate bit only.
// - Processor uncorrectable errors overwrite the log over any other type.
// - Other uncorrectable errors overwrite unless a processor uncorrectable is logged.
// - Single-bit errors load the log only as first error since clear.
// - Cycle-type bit is one for write cycles, zero for reads.
// - Two log bits return a fixed unit identification code.
// - Density bit is one for 64K devices, zero for 16K devices.
// - Address field holds the low eight active address bits and two stack pointer bits.
// - Low six log bits hold the syndrome of the logged error.
// - Five diagnostic operations are selected by the diagnostic micro.
// - Echo write data returns all 24 write bits in place.
// - Echo address returns ten active-selector bits, plus or minus 16.
// - Raw write stores 16 data bits plus six write bits as check bits.
// - Raw read returns 16 data bits, odd parity and six raw check bits.
// - Read log drives the log out, then clears it.
package mel_pkg;

  localparam int          LOG_W        = 24;
  localparam int          LOG_DUP      = 23;
  localparam int          LOG_PU       = 22;
  localparam int          LOG_NU       = 21;
  localparam int          LOG_SE       = 20;
  localparam int          LOG_WR       = 19;
  localparam int          LOG_ID_LO    = 17;
  localparam int          LOG_DEN      = 16;
  localparam int          LOG_ADR_LO   = 8;
  localparam int          LOG_ASP_LO   = 6;
  localparam int          ECHO_LO      = 6;
  localparam int          RAW_PAR      = 22;
  localparam int          CHK_LO       = 16;
  localparam logic [23:0] LOG_RST      = 24'h000000;
  // Arbitrary identification value
  localparam logic [1:0]  MEL_ID_CODE  = 2'h2;
  localparam logic [4:0]  FULL_FIELD   = 5'h10;
  localparam logic [9:0]  STACK_STEP   = 10'h010;

  typedef enum logic [2:0] {
    DG_ECHO_WD = 3'b000,
    DG_ECHO_AD = 3'b001,
    DG_RAW_WR  = 3'b010,
    DG_RAW_RD  = 3'b011,
    DG_RD_LOG  = 3'b100
  } mel_diag_t;

  // Column code of data bit i: the i-th weight-three 6-bit value
  function automatic logic [5:0] mel_col(input int i);
    int n;
    n = 0;
    mel_col = 6'h00;
    for (int c = 0; c < 64; c++) begin
      if ($countones(6'(c)) == 3) begin
        if (n == i) mel_col = 6'(c);
        n++;
      end
    end
  endfunction : mel_col

  function automatic logic [5:0] mel_chk(input logic [15:0] d);
    mel_chk = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) mel_chk = mel_chk ^ mel_col(i);
    end
  endfunction : mel_chk

  // Active address one stack step forward or back
  function automatic logic [9:0] mel_step(input logic [9:0] a, input logic rev);
    mel_step = rev ? a - STACK_STEP : a + STACK_STEP;
  endfunction : mel_step

endpackage : mel_pkg

// ---- mel_ecc_gen.sv ----
// Check-bit generation for the storage write word.
// Assumes the caller registers the result.
`timescale 1ns/100ps
module mel_ecc_gen
  import mel_pkg::*;
(
  input  wire logic [15:0] i_data,
  input  wire logic [5:0]  i_raw_chk,
  input  wire logic        i_raw,
  input  wire logic        i_invert,
  output logic      [5:0]  o_chk
);
  wire logic [5:0] gen_chk = mel_chk(i_data);
  wire logic [5:0] inv_chk = i_invert ? ~gen_chk : gen_chk;
  // Raw write substitutes write bits for generated check bits
  assign o_chk = i_raw ? i_raw_chk : inv_chk;
endmodule : mel_ecc_gen

// ---- mel_syn_decode.sv ----
// Syndrome generation, classification and single-bit correction.
// Assumes the word is sampled in the cycle it is presented.
`timescale 1ns/100ps
module mel_syn_decode
  import mel_pkg::*;
(
  input  wire logic [21:0] i_word,
  input  wire logic        i_enable,
  output logic      [15:0] o_data,
  output logic      [5:0]  o_syndrome,
  output logic             o_single,
  output logic             o_uncorr
);
  logic [15:0] flip;
  wire logic [5:0] syn     = i_word[21:16] ^ mel_chk(i_word[15:0]);
  wire logic       chk_hit = $countones(syn) == 1;

  always_comb begin
    flip = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      flip[i] = syn == mel_col(i);
    end
  end

  assign o_syndrome = syn;
  assign o_data     = i_word[15:0] ^ flip;
  assign o_single   = i_enable && (chk_hit || |flip);
  assign o_uncorr   = i_enable && syn != 6'h00 && !chk_hit && !(|flip);
endmodule : mel_syn_decode

// ---- mel_memory_base_unit.sv ----
// Error log, limit check and diagnostic data paths of the memory base unit.
// Assumes the read word is valid in the cycle an operation or diagnostic is taken.
`timescale 1ns/100ps
module mel_memory_base_unit
  import mel_pkg::*;
#(
  parameter int AW = 18
)(
  input  wire logic          i_ref_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_op_valid,
  input  wire logic          i_op_write,
  input  wire logic          i_op_proc,
  input  wire logic          i_op_reverse,
  input  wire logic          i_cross_stack,
  input  wire logic [4:0]    i_field_len,
  input  wire logic [1:0]    i_stack_sel,
  input  wire logic [AW-1:0] i_op_addr,
  input  wire logic [AW-1:0] i_mem_limit,
  input  wire logic [21:0]   i_rd_word,
  input  wire logic [23:0]   i_wr_data,
  input  wire logic          i_diag_valid,
  input  wire logic [2:0]    i_diag_op,
  input  wire logic          i_density_64k,
  output logic               o_rd_valid,
  output logic      [23:0]   o_rd_data,
  output logic               o_wr_en,
  output logic      [21:0]   o_wr_word,
  output logic               o_uncorrectable_signal,
  output logic               o_log_changed,
  output logic               o_addr_out_of_range
);

  if (AW < 10) begin : g_bad_aw
    $error("address width below ten bits");
  end

  logic [23:0] log_q;
  logic [23:0] log_d;
  logic        load;
  logic        dup;
  logic        ev_se_q;
  logic        ev_uc_q;
  logic        ev_proc_q;
  logic        ev_wr_q;
  logic [7:0]  ev_adr_q;
  logic [1:0]  ev_asp_q;
  logic [5:0]  ev_syn_q;
  logic        rd_valid_q;
  logic [23:0] rd_data_q;
  logic        wr_en_q;
  logic [21:0] wr_word_q;
  logic        uncorr_q;
  logic        changed_q;
  logic        oob_q;
  logic [15:0] cor_data;
  logic [5:0]  syndrome;
  logic        dec_single;
  logic        dec_uncorr;
  logic [5:0]  wr_chk;

  // Operation decode
  wire mel_diag_t dop     = mel_diag_t'(i_diag_op);
  wire logic      echo_wd = i_diag_valid && dop == DG_ECHO_WD;
  wire logic      echo_ad = i_diag_valid && dop == DG_ECHO_AD;
  wire logic      raw_wr  = i_diag_valid && dop == DG_RAW_WR;
  wire logic      raw_rd  = i_diag_valid && dop == DG_RAW_RD;
  wire logic      rd_log  = i_diag_valid && dop == DG_RD_LOG;
  wire logic      norm    = i_op_valid && !i_diag_valid;
  wire logic      n_wr    = norm && i_op_write;
  wire logic      chk_off = n_wr && i_cross_stack && i_field_len == FULL_FIELD;
  wire logic      inv_chk = n_wr && i_field_len < FULL_FIELD;
  wire logic      dec_en  = norm && !chk_off;
  wire logic      any_err = dec_single || dec_uncorr;

  // Stack-modified address and stack pointer code {hi, lo}
  wire logic [9:0] base_adr = i_op_addr[9:0];
  wire logic [9:0] act_adr  = i_stack_sel == 2'h0 ? base_adr
                                                 : mel_step(base_adr, i_op_reverse);
  wire logic [9:0] echo_adr = mel_step(base_adr, i_op_reverse);
  wire logic [1:0] asp_code = i_stack_sel == 2'h1 ? 2'b01
                            : i_stack_sel == 2'h2 ? 2'b10 : 2'b00;

  // Log as seen on a read, fixed fields overlaid
  wire logic [23:0] log_view = {log_q[23:19], MEL_ID_CODE, i_density_64k,
                                log_q[15:0]};
  wire logic [23:0] log_base = rd_log ? LOG_RST : log_q;

  // Read return selection
  wire logic        rd_take  = (norm && !i_op_write) || echo_wd || echo_ad
                             || raw_rd || rd_log;
  wire logic        par_odd  = ~^cor_data;
  wire logic [23:0] raw_ret  = {1'b0, par_odd, i_rd_word[21:16], cor_data};
  wire logic [23:0] echo_ret = {8'h00, echo_adr, 6'h00};
  wire logic [23:0] rd_mux   = echo_wd ? i_wr_data
                             : echo_ad ? echo_ret
                             : raw_rd  ? raw_ret
                             : rd_log  ? log_view
                             : {8'h00, cor_data};
  wire logic        wr_take  = n_wr || raw_wr;
  wire logic        oob      = norm && i_op_addr >= i_mem_limit;

  mel_syn_decode u_dec (
    .i_word     (i_rd_word),
    .i_enable   (dec_en),
    .o_data     (cor_data),
    .o_syndrome (syndrome),
    .o_single   (dec_single),
    .o_uncorr   (dec_uncorr)
  );

  mel_ecc_gen u_gen (
    .i_data    (i_wr_data[15:0]),
    .i_raw_chk (i_wr_data[21:16]),
    .i_raw     (raw_wr),
    .i_invert  (inv_chk),
    .o_chk     (wr_chk)
  );

  // Error priority and log update; an event wins over a same-cycle clear
  always_comb begin
    log_d = log_base;
    load  = 1'b0;
    dup   = 1'b0;
    if (ev_uc_q && ev_proc_q) begin
      load           = !log_base[LOG_PU];
      dup            = log_base[LOG_PU];
      log_d[LOG_PU]  = 1'b1;
    end else if (ev_uc_q) begin
      load           = !(log_base[LOG_PU] || log_base[LOG_NU]);
      dup            = log_base[LOG_NU];
      log_d[LOG_NU]  = 1'b1;
    end else if (ev_se_q) begin
      load           = !(log_base[LOG_PU] || log_base[LOG_NU]
                         || log_base[LOG_SE]);
      dup            = log_base[LOG_SE];
      log_d[LOG_SE]  = 1'b1;
    end
    if (load) begin
      log_d[LOG_WR]                 = ev_wr_q;
      log_d[LOG_ADR_LO +: 8]        = ev_adr_q;
      log_d[LOG_ASP_LO +: 2]        = ev_asp_q;
      log_d[5:0]                    = ev_syn_q;
    end
    if (dup) begin
      log_d[LOG_DUP] = 1'b1;
    end
  end

  // Error capture stage
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ev_se_q   <= 1'b0;
      ev_uc_q   <= 1'b0;
      ev_proc_q <= 1'b0;
      ev_wr_q   <= 1'b0;
      ev_adr_q  <= 8'h00;
      ev_asp_q  <= 2'h0;
      ev_syn_q  <= 6'h00;
    end else begin
      ev_se_q   <= dec_single;
      ev_uc_q   <= dec_uncorr;
      if (any_err) begin
        ev_proc_q <= i_op_proc;
        ev_wr_q   <= i_op_write;
        ev_adr_q  <= act_adr[7:0];
        ev_asp_q  <= asp_code;
        ev_syn_q  <= syndrome;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      log_q     <= LOG_RST;
      changed_q <= 1'b0;
    end else begin
      log_q     <= log_d;
      changed_q <= ev_se_q || ev_uc_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 24'h000000;
      wr_en_q    <= 1'b0;
      wr_word_q  <= 22'h000000;
      uncorr_q   <= 1'b0;
      oob_q      <= 1'b0;
    end else begin
      rd_valid_q <= rd_take;
      if (rd_take) rd_data_q <= rd_mux;
      wr_en_q    <= wr_take;
      if (wr_take) wr_word_q <= {wr_chk, i_wr_data[15:0]};
      uncorr_q   <= dec_uncorr;
      oob_q      <= oob;
    end
  end

  assign o_rd_valid             = rd_valid_q;
  assign o_rd_data              = rd_data_q;
  assign o_wr_en                = wr_en_q;
  assign o_wr_word              = wr_word_q;
  assign o_uncorrectable_signal = uncorr_q;
  assign o_log_changed          = changed_q;
  assign o_addr_out_of_range    = oob_q;

  // Checks
  a_uncorr_pulse : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dec_uncorr |=> o_uncorrectable_signal ##1 o_log_changed)
    else $error("uncorrectable error not reported");

  a_stack_mute : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    chk_off |=> !o_uncorrectable_signal && !ev_se_q)
    else $error("error reported on stack-crossing write");

  a_inv_check : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    inv_chk |=> o_wr_en && o_wr_word[21:16] == ~mel_chk(o_wr_word[15:0]))
    else $error("short write check bits not inverted");

  a_limit_flag : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    norm && i_op_addr >= i_mem_limit |=> o_addr_out_of_range)
    else $error("out-of-range address not flagged");

  a_pu_overwrite : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && ev_proc_q && !log_q[LOG_PU] && !rd_log |=>
      log_q[5:0] == $past(ev_syn_q) && log_q[LOG_PU])
    else $error("processor uncorrectable error did not take the log");

  a_se_hold : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_se_q && !ev_uc_q && log_q[LOG_SE] && !rd_log |=>
      log_q[15:0] == $past(log_q[15:0]) && log_q[LOG_DUP])
    else $error("later single-bit error altered the log");

  a_changed_late : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dec_single |-> ##2 o_log_changed)
    else $error("log change not signalled");

  a_echo_data : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    echo_wd |=> o_rd_valid && o_rd_data == $past(i_wr_data))
    else $error("echoed write data differs");

  a_raw_parity : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    raw_rd |=> o_rd_valid && ^{o_rd_data[RAW_PAR], o_rd_data[15:0]})
    else $error("raw read parity not odd");

  a_log_cleared : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    rd_log && !ev_se_q && !ev_uc_q |=> log_q == LOG_RST)
    else $error("log not cleared after read");

  a_uncorr_class : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dec_en && $countones(syndrome) == 2 |-> dec_uncorr && !dec_single)
    else $error("double-bit syndrome not uncorrectable");

  a_read_correct : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    norm && !i_op_write && dec_single && $countones(syndrome) != 1 |=>
      mel_chk(o_rd_data[15:0]) == $past(i_rd_word[21:16]))
    else $error("single-bit data error not corrected");

  a_rd_plain : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    norm && !i_op_write |=> o_rd_valid && o_rd_data[23:16] == 8'h00)
    else $error("normal read return malformed");

  a_se_continue : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dec_single |=> !o_uncorrectable_signal)
    else $error("single-bit error raised uncorrectable");

  a_changed_idle : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !ev_se_q && !ev_uc_q |=> !o_log_changed)
    else $error("log change without an event");

  a_pu_type : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && ev_proc_q |=> log_q[LOG_PU])
    else $error("processor uncorrectable type not logged");

  a_nu_type : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && !ev_proc_q |=> log_q[LOG_NU])
    else $error("other uncorrectable type not logged");

  a_full_check : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    n_wr && i_field_len >= FULL_FIELD |=> o_wr_word[21:16] == mel_chk(o_wr_word[15:0]))
    else $error("full write check bits wrong");

  a_range_clear : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    norm && i_op_addr < i_mem_limit |=> !o_addr_out_of_range)
    else $error("in-range address flagged");

  a_pu_dup : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && ev_proc_q && log_q[LOG_PU] && !rd_log |=>
      log_q[LOG_DUP] && log_q[15:0] == $past(log_q[15:0]))
    else $error("repeated processor error altered the log");

  a_nu_dup : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && !ev_proc_q && log_q[LOG_NU] && !rd_log |=> log_q[LOG_DUP])
    else $error("repeated other error not marked duplicate");

  a_nu_overwrite : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && !ev_proc_q && !log_q[LOG_PU] && !log_q[LOG_NU] && !rd_log |=>
      log_q[5:0] == $past(ev_syn_q))
    else $error("other uncorrectable error did not take the log");

  a_nu_keep : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_uc_q && !ev_proc_q && log_q[LOG_PU] && !rd_log |=> log_q[15:0] == $past(log_q[15:0]))
    else $error("other error overwrote a processor error");

  a_se_first : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ev_se_q && !ev_uc_q && log_q[22:20] == 3'b000 && !rd_log |=>
      log_q[5:0] == $past(ev_syn_q) && log_q[LOG_SE])
    else $error("first single-bit error not loaded");

  a_wr_bit : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    load |=> log_q[LOG_WR] == $past(ev_wr_q))
    else $error("cycle type bit wrong");

  a_id_view : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    rd_log |=> o_rd_valid && o_rd_data[LOG_ID_LO +: 2] == MEL_ID_CODE)
    else $error("identification bits wrong");

  a_density_view : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    rd_log |=> o_rd_data[LOG_DEN] == $past(i_density_64k))
    else $error("density bit wrong");

  a_addr_field : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    load |=> log_q[15:6] == $past({ev_adr_q, ev_asp_q}))
    else $error("address field not loaded");

  a_illegal_diag : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_diag_valid && i_diag_op > 3'h4 |=> !o_rd_valid && !o_wr_en)
    else $error("illegal diagnostic code answered");

  a_echo_addr : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    echo_ad |=> o_rd_data[ECHO_LO +: 10] ==
      $past(i_op_reverse ? i_op_addr[9:0] - STACK_STEP : i_op_addr[9:0] + STACK_STEP))
    else $error("echoed address wrong");

  a_raw_write : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    raw_wr |=> o_wr_en && o_wr_word == $past(i_wr_data[21:0]))
    else $error("raw write word wrong");

  a_raw_quiet : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    raw_wr || raw_rd |=> !o_uncorrectable_signal)
    else $error("raw operation reported an error");

  a_raw_read : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    raw_rd |=> o_rd_data[21:16] == $past(i_rd_word[21:16]) && !o_rd_data[23])
    else $error("raw read check bits wrong");

  a_reset_clear : assert property (@(posedge i_ref_clk)
    i_sys_rst |=> log_q == LOG_RST && !o_log_changed && !o_rd_valid)
    else $error("reset left the log set");

endmodule : mel_memory_base_unit

// ---- mel_proc_model.sv ----
// Processor-side memory error flags, set from the unit's error signals.
// Assumes it shares the unit's clock and synchronous reset.
`timescale 1ns/100ps
module mel_proc_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_uncorrectable_signal,
  input  wire logic       i_log_changed,
  input  wire logic       i_addr_out_of_range,
  output logic      [2:0] o_error_flags
);
  logic [2:0] flag_set;

  // Bit 0 uncorrectable, bit 1 log changed (single-bit or uncorrectable), bit 2 out of range
  assign flag_set = {i_addr_out_of_range, i_log_changed, i_uncorrectable_signal};

  // Flags stay set until reset
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_error_flags <= 3'h0;
    end else begin
      o_error_flags <= o_error_flags | flag_set;
    end
  end
endmodule : mel_proc_model

// ---- test_memory_error_log_and_diagnostics.sv ----
// Self-checking bench for the memory base unit error log and diagnostics.
// Assumes the processor flag model in mel_proc_model.sv.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_memory_error_log_and_diagnostics
  import mel_pkg::*;
;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst, i_op_valid, i_op_write, i_op_proc, i_op_reverse, i_cross_stack;
  logic        i_diag_valid, i_density_64k;
  logic [4:0]  i_field_len;
  logic [1:0]  i_stack_sel;
  logic [17:0] i_op_addr, i_mem_limit;
  logic [21:0] i_rd_word, o_wr_word;
  logic [23:0] i_wr_data, o_rd_data;
  logic [2:0]  i_diag_op, flags;
  logic        o_rd_valid, o_wr_en, o_uncorrectable_signal, o_log_changed, o_addr_out_of_range;
  logic        s_rv, s_we, s_ue, s_oor, s_lc;
  int          num_errors = 0;
  int          comparisons = 0;
  // Identification code and 64K density bit as read back from the log
  localparam logic [23:0] BASE = {5'h00, MEL_ID_CODE, 1'b1, 16'h0000};

  always #20 i_ref_clk = ~i_ref_clk;

  mel_memory_base_unit #(.AW(18)) i_mel_memory_base_unit (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_op_valid(i_op_valid),
    .i_op_write(i_op_write), .i_op_proc(i_op_proc), .i_op_reverse(i_op_reverse),
    .i_cross_stack(i_cross_stack), .i_field_len(i_field_len), .i_stack_sel(i_stack_sel),
    .i_op_addr(i_op_addr), .i_mem_limit(i_mem_limit), .i_rd_word(i_rd_word),
    .i_wr_data(i_wr_data), .i_diag_valid(i_diag_valid), .i_diag_op(i_diag_op),
    .i_density_64k(i_density_64k), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_wr_en(o_wr_en), .o_wr_word(o_wr_word), .o_uncorrectable_signal(o_uncorrectable_signal),
    .o_log_changed(o_log_changed), .o_addr_out_of_range(o_addr_out_of_range));

  mel_proc_model i_mel_proc_model (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_uncorrectable_signal(o_uncorrectable_signal), .i_log_changed(o_log_changed),
    .i_addr_out_of_range(o_addr_out_of_range), .o_error_flags(flags));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic setop(input logic wr, pr, rv, input logic [1:0] ss, input logic [9:0] a,
                       input logic [21:0] w);
    i_op_write   = wr;
    i_op_proc    = pr;
    i_op_reverse = rv;
    i_stack_sel  = ss;
    i_op_addr    = {8'h00, a};
    i_rd_word    = w;
  endtask : setop

  // One take, then sample the one-cycle answers and the later log event
  task automatic issue(input logic dv, input logic [2:0] dop);
    i_op_valid   = ~dv;
    i_diag_valid = dv;
    i_diag_op    = dop;
    @(negedge i_ref_clk);
    i_op_valid   = 1'b0;
    i_diag_valid = 1'b0;
    s_rv  = o_rd_valid;
    s_we  = o_wr_en;
    s_ue  = o_uncorrectable_signal;
    s_oor = o_addr_out_of_range;
    @(negedge i_ref_clk);
    s_lc  = o_log_changed;
  endtask : issue

  task automatic err_op(input logic wr, pr, rv, input logic [1:0] ss, input logic [9:0] a,
                        input logic [21:0] w, input logic ue);
    setop(wr, pr, rv, ss, a, w);
    issue(1'b0, 3'h0);
    `CHK("uncorrectable", ue, s_ue)
    `CHK("log changed", 1'b1, s_lc)
  endtask : err_op

  task automatic rdlog(input logic [23:0] exp);
    issue(1'b1, 3'h4);
    `CHK("log valid", 1'b1, s_rv)
    `CHK("error log", exp, o_rd_data)
  endtask : rdlog

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done

  // Whole run is about 54 cycles
  initial begin
    repeat (2000) @(posedge i_ref_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    i_sys_rst = 1'b1; i_op_valid = 1'b0; i_diag_valid = 1'b0; i_diag_op = 3'h0;
    i_density_64k = 1'b1; i_field_len = 5'h18; i_cross_stack = 1'b0;
    i_mem_limit = 18'h3ffff; i_wr_data = 24'h000000;
    setop(1'b0, 1'b1, 1'b0, 2'h0, 10'h000, 22'h000000);
    repeat (4) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    rdlog(BASE);
    issue(1'b0, 3'h0);
    `CHK("clean event", 1'b0, s_lc)
    done("reset and clean read");
    // Data bit 0 flipped, then check bit 0 flipped
    err_op(1'b0, 1'b1, 1'b0, 2'h0, 10'h0a5, 22'h000001, 1'b0);
    `CHK("corrected data", 24'h000000, o_rd_data)
    err_op(1'b0, 1'b1, 1'b0, 2'h0, 10'h011, 22'h010000, 1'b0);
    rdlog(BASE | 24'h90a507);
    rdlog(BASE);
    `CHK("flags single", 3'b010, flags)
    done("single-bit log");
    err_op(1'b0, 1'b1, 1'b0, 2'h0, 10'h200, 22'h000001, 1'b0);
    err_op(1'b1, 1'b0, 1'b0, 2'h1, 10'h123, 22'h000003, 1'b1);
    rdlog(BASE | 24'h38334c);
    err_op(1'b0, 1'b0, 1'b0, 2'h0, 10'h040, 22'h000003, 1'b1);
    err_op(1'b0, 1'b1, 1'b1, 2'h2, 10'h080, 22'h000003, 1'b1);
    err_op(1'b0, 1'b0, 1'b0, 2'h0, 10'h044, 22'h000003, 1'b1);
    rdlog(BASE | 24'he0708c);
    `CHK("flags uncorrectable", 3'b011, flags)
    done("priority log");
    i_field_len = 5'h10;
    i_cross_stack = 1'b1;
    setop(1'b1, 1'b1, 1'b0, 2'h0, 10'h050, 22'h000003);
    issue(1'b0, 3'h0);
    `CHK("cross uncorr", 1'b0, s_ue)
    `CHK("cross event", 1'b0, s_lc)
    rdlog(BASE);
    i_cross_stack = 1'b0;
    // Lowest weight-three column is 6'h07; short fields store it inverted
    i_wr_data = 24'h000001;
    setop(1'b1, 1'b1, 1'b0, 2'h0, 10'h050, 22'h000000);
    for (int k = 0; k < 2; k++) begin
      i_field_len = k ? 5'h18 : 5'h08;
      issue(1'b0, 3'h0);
      `CHK("write valid", 1'b1, s_we)
      `CHK("write word", {k ? 6'h07 : 6'h38, 16'h0001}, o_wr_word)
    end
    i_mem_limit = 18'h00400;
    for (int k = 0; k < 2; k++) begin
      setop(1'b0, 1'b1, 1'b0, 2'h0, 10'h3ff, 22'h000000);
      i_op_addr = 18'h003ff + 18'(k);
      issue(1'b0, 3'h0);
      `CHK("out of range", 1'(k), s_oor)
    end
    `CHK("flags range", 3'b111, flags)
    done("write checks and limits");
    i_wr_data = 24'hc3a5f1;
    issue(1'b1, 3'h0);
    `CHK("echo data", 24'hc3a5f1, o_rd_data)
    for (int k = 0; k < 2; k++) begin
      setop(1'b0, 1'b1, 1'(k), 2'h1, 10'h123, 22'h000000);
      issue(1'b1, 3'h1);
      `CHK("echo addr", {8'h00, k ? 10'h113 : 10'h133, 6'h00}, o_rd_data)
    end
    i_wr_data = 24'h2a1234;
    issue(1'b1, 3'h2);
    `CHK("raw write", 22'h2a1234, o_wr_word)
    i_rd_word = 22'h0c0003;
    issue(1'b1, 3'h3);
    `CHK("raw read", 24'h4c0003, o_rd_data)
    `CHK("raw event", 1'b0, s_lc)
    issue(1'b1, 3'h5);
    `CHK("illegal read", 1'b0, s_rv)
    `CHK("illegal write", 1'b0, s_we)
    done("diagnostics");
    end_sim();
  end
endmodule : test_memory_error_log_and_diagnostics
